// ---- hdl/mcsb_regs.vh ----
// Constants of the motor control status bank: register offsets, field positions,
// reset values and control state codes.
// Assumes an 8-bit register offset delivered by the serial control front end.
`ifndef MCSB_REGS_VH
`define MCSB_REGS_VH

// ==========================================================================
// Register offsets
`define MCSB_ADDR_W 8
`define MCSB_OFS_CTRL_FAULT 8'hE2
`define MCSB_OFS_STATUS_VOLT 8'hE4
`define MCSB_OFS_STATUS_STATE 8'hEA
`define MCSB_OFS_STATUS_POWER 8'hEC
`define MCSB_RESET_VALUE 32'h0000_0000

// ==========================================================================
// Controller fault field positions
`define MCSB_BIT_FAULT_SUMMARY 31
`define MCSB_BIT_POSDET_FREQ 29
`define MCSB_BIT_POSDET_T1 28
`define MCSB_BIT_POSDET_T2 27
`define MCSB_BIT_SPEED_LOCK 23
`define MCSB_BIT_SYNC_LOST 22
`define MCSB_BIT_MOTOR_ABSENT 21
`define MCSB_BIT_LOCK_ANY 20
`define MCSB_BIT_CYCLE_ILIM 19
`define MCSB_BIT_LOCK_ILIM 18
`define MCSB_BIT_SUPPLY_LOW 17
`define MCSB_BIT_SUPPLY_HIGH 16
`define MCSB_BIT_WDOG 15
`define MCSB_BIT_SELFTEST_EN 2
`define MCSB_BIT_SELFTEST_PASS 1
`define MCSB_BIT_APP_RESET_OK 0
`define MCSB_NUM_FAULTS 12

// ==========================================================================
// Status field positions
`define MCSB_BIT_SELFTEST_FAULT 17
`define MCSB_BIT_SERIAL_ENTRY 0

// ==========================================================================
// Control state codes
`define MCSB_ST_SYS_IDLE 4'h0
`define MCSB_ST_START 4'h1
`define MCSB_ST_RUN 4'h2
`define MCSB_ST_INIT 4'h3
`define MCSB_ST_POSDET 4'h4
`define MCSB_ST_ALIGN 4'h5
`define MCSB_ST_MOTOR_IDLE 4'h6
`define MCSB_ST_STOP 4'h7
`define MCSB_ST_FAULT 4'h8
`define MCSB_ST_DIRECTION 4'h9
`define MCSB_ST_SENSOR_ALIGN 4'hA
`define MCSB_ST_FREEWHEEL 4'hC
`define MCSB_ST_BRAKE 4'hD

`endif

// ---- hdl/mcsb_sticky_flags.v ----
// Bank of sticky fault flags with a common clear.
// Assumes set inputs are synchronous to clk; a set in the clear cycle survives.
`timescale 1ns/100ps
module mcsb_sticky_flags #(
  parameter WIDTH = 12
) (
  clk,
  rst,
  clkEn,
  clearAll,
  setIn,
  flags
);
  input wire clk;
  input wire rst;
  input wire clkEn;
  input wire clearAll;
  input wire [WIDTH-1:0] setIn;
  output wire [WIDTH-1:0] flags;

  // ==========================================================================
  // One flag per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gFlag
      reg flag_q;
      wire flag_d;
      // Set wins over clear so that an event in the clear cycle is not lost.
      assign flag_d = setIn[i] | (flag_q & ~clearAll);
      always @(posedge clk) begin
        if (rst) begin
          flag_q <= 1'b0;
        end else if (clkEn) begin
          flag_q <= flag_d;
        end
      end
      assign flags[i] = flag_q;
    end
  endgenerate
endmodule // mcsb_sticky_flags

// ---- hdl/mcsb_status_bank.v ----
// Read-only status register bank of the motor controller.
// Assumes the serial control front end issues one-cycle read or write strobes
// with an 8-bit offset, and that all fault and measurement inputs are synchronous.
`timescale 1ns/100ps
`include "mcsb_regs.vh"
module mcsb_status_bank #(
  parameter VOLT_W = 16,
  parameter SPDCMD_W = 15,
  parameter SPEED_W = 16
) (
  clk,
  rst,
  clkEn,
  posdetFreqFault,
  posdetTiming1Fault,
  posdetTiming2Fault,
  abnormalSpeedLock,
  syncLostLock,
  motorAbsentFault,
  cycleCurrentLimitFault,
  lockCurrentLimitFault,
  motorSupplyLow,
  motorSupplyHigh,
  extWatchdogExpired,
  clearFaultsCmd,
  selftestEnabled,
  selftestPass,
  selftestFault,
  appResetOk,
  statusLoad,
  serialEntryDone,
  inputVoltageValue,
  voltageValid,
  speedCmdValue,
  speedCmdValid,
  ctrlState,
  motorSpeedValue,
  motorSpeedValid,
  busCurrentValue,
  inputPowerValue,
  powerValid,
  regAddr,
  regRdEn,
  regWrEn,
  regWrData,
  regRdData,
  regAck,
  regAddrErr,
  faultSummary,
  motorLockAny
);
  input wire clk;
  input wire rst;
  input wire clkEn;
  input wire posdetFreqFault;
  input wire posdetTiming1Fault;
  input wire posdetTiming2Fault;
  input wire abnormalSpeedLock;
  input wire syncLostLock;
  input wire motorAbsentFault;
  input wire cycleCurrentLimitFault;
  input wire lockCurrentLimitFault;
  input wire motorSupplyLow;
  input wire motorSupplyHigh;
  input wire extWatchdogExpired;
  input wire clearFaultsCmd;
  input wire selftestEnabled;
  input wire selftestPass;
  input wire selftestFault;
  input wire appResetOk;
  input wire statusLoad;
  input wire serialEntryDone;
  input wire [VOLT_W-1:0] inputVoltageValue;
  input wire voltageValid;
  input wire [SPDCMD_W-1:0] speedCmdValue;
  input wire speedCmdValid;
  input wire [3:0] ctrlState;
  input wire [SPEED_W-1:0] motorSpeedValue;
  input wire motorSpeedValid;
  input wire [15:0] busCurrentValue;
  input wire [15:0] inputPowerValue;
  input wire powerValid;
  input wire [`MCSB_ADDR_W-1:0] regAddr;
  input wire regRdEn;
  input wire regWrEn;
  input wire [31:0] regWrData;
  output reg [31:0] regRdData;
  output reg regAck;
  output reg regAddrErr;
  output reg faultSummary;
  output wire motorLockAny;

  // ==========================================================================
  // Offset decode
  localparam SEL_NONE = 3'd0;
  localparam SEL_FAULT = 3'd1;
  localparam SEL_VOLT = 3'd2;
  localparam SEL_STATE = 3'd3;
  localparam SEL_POWER = 3'd4;

  // Shared by the read path and the write acknowledge path.
  function [2:0] decodeOffset;
    input [`MCSB_ADDR_W-1:0] ofs;
    begin
      case (ofs)
        `MCSB_OFS_CTRL_FAULT: decodeOffset = SEL_FAULT;
        `MCSB_OFS_STATUS_VOLT: decodeOffset = SEL_VOLT;
        `MCSB_OFS_STATUS_STATE: decodeOffset = SEL_STATE;
        `MCSB_OFS_STATUS_POWER: decodeOffset = SEL_POWER;
        default: decodeOffset = SEL_NONE;
      endcase
    end
  endfunction

  // Only the documented codes are accepted; others keep the last good state.
  function stateKnown;
    input [3:0] code;
    begin
      case (code)
        `MCSB_ST_SYS_IDLE, `MCSB_ST_START, `MCSB_ST_RUN, `MCSB_ST_INIT,
        `MCSB_ST_POSDET, `MCSB_ST_ALIGN, `MCSB_ST_MOTOR_IDLE, `MCSB_ST_STOP,
        `MCSB_ST_FAULT, `MCSB_ST_DIRECTION, `MCSB_ST_SENSOR_ALIGN,
        `MCSB_ST_FREEWHEEL, `MCSB_ST_BRAKE: stateKnown = 1'b1;
        default: stateKnown = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================================
  // Sticky controller fault flags
  wire lockDetect;
  wire [`MCSB_NUM_FAULTS-1:0] faultSet;
  wire [`MCSB_NUM_FAULTS-1:0] faultFlags;

  assign lockDetect = abnormalSpeedLock | syncLostLock | motorAbsentFault |
    lockCurrentLimitFault;

  assign faultSet = {
    posdetFreqFault,
    posdetTiming1Fault,
    posdetTiming2Fault,
    abnormalSpeedLock,
    syncLostLock,
    motorAbsentFault,
    lockDetect,
    cycleCurrentLimitFault,
    lockCurrentLimitFault,
    motorSupplyLow,
    motorSupplyHigh,
    extWatchdogExpired
  };

  mcsb_sticky_flags #(
    .WIDTH(`MCSB_NUM_FAULTS)
  ) uFaults (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .clearAll(clearFaultsCmd),
    .setIn(faultSet),
    .flags(faultFlags)
  );

  assign motorLockAny = faultFlags[5];

  // ==========================================================================
  // Self-test and reset status bits
  reg selftestEn_q;
  reg selftestPass_q;
  reg appResetOk_q;
  reg selftestFault_q;
  reg serialEntry_q;

  // These are status, not faults, so the clear command leaves them alone.
  always @(posedge clk) begin
    if (rst) begin
      selftestEn_q <= 1'b0;
      selftestPass_q <= 1'b0;
      appResetOk_q <= 1'b0;
      selftestFault_q <= 1'b0;
      serialEntry_q <= 1'b0;
    end else if (clkEn) begin
      if (statusLoad) begin
        selftestEn_q <= selftestEnabled;
        selftestPass_q <= selftestPass;
        appResetOk_q <= appResetOk;
        selftestFault_q <= selftestFault;
      end
      serialEntry_q <= serialEntryDone;
    end
  end

  // ==========================================================================
  // Measured values
  reg [VOLT_W-1:0] voltage_q;
  reg [SPDCMD_W-1:0] speedCmd_q;
  reg [3:0] state_q;
  reg [SPEED_W-1:0] speed_q;
  reg [15:0] busCurrent_q;
  reg [15:0] power_q;

  // Each measured value changes only on its valid strobe, bus current and power both on powerValid; the state follows every known ctrlState code.
  always @(posedge clk) begin
    if (rst) begin
      voltage_q <= {VOLT_W{1'b0}};
      speedCmd_q <= {SPDCMD_W{1'b0}};
      state_q <= `MCSB_ST_SYS_IDLE;
      speed_q <= {SPEED_W{1'b0}};
      busCurrent_q <= 16'h0000;
      power_q <= 16'h0000;
    end else if (clkEn) begin
      if (voltageValid) begin
        voltage_q <= inputVoltageValue;
      end
      if (speedCmdValid) begin
        speedCmd_q <= speedCmdValue;
      end
      if (stateKnown(ctrlState)) begin
        state_q <= ctrlState;
      end
      if (motorSpeedValid) begin
        speed_q <= motorSpeedValue;
      end
      if (powerValid) begin
        busCurrent_q <= busCurrentValue;
        power_q <= inputPowerValue;
      end
    end
  end

  // ==========================================================================
  // Register images
  reg [31:0] faultWord;
  reg [31:0] voltWord;
  reg [31:0] stateWord;
  reg [31:0] powerWord;

  always @* begin
    faultWord = `MCSB_RESET_VALUE;
    faultWord[`MCSB_BIT_FAULT_SUMMARY] = |faultFlags;
    faultWord[`MCSB_BIT_POSDET_FREQ] = faultFlags[11];
    faultWord[`MCSB_BIT_POSDET_T1] = faultFlags[10];
    faultWord[`MCSB_BIT_POSDET_T2] = faultFlags[9];
    faultWord[`MCSB_BIT_SPEED_LOCK] = faultFlags[8];
    faultWord[`MCSB_BIT_SYNC_LOST] = faultFlags[7];
    faultWord[`MCSB_BIT_MOTOR_ABSENT] = faultFlags[6];
    faultWord[`MCSB_BIT_LOCK_ANY] = faultFlags[5];
    faultWord[`MCSB_BIT_CYCLE_ILIM] = faultFlags[4];
    faultWord[`MCSB_BIT_LOCK_ILIM] = faultFlags[3];
    faultWord[`MCSB_BIT_SUPPLY_LOW] = faultFlags[2];
    faultWord[`MCSB_BIT_SUPPLY_HIGH] = faultFlags[1];
    faultWord[`MCSB_BIT_WDOG] = faultFlags[0];
    faultWord[`MCSB_BIT_SELFTEST_EN] = selftestEn_q;
    faultWord[`MCSB_BIT_SELFTEST_PASS] = selftestPass_q;
    faultWord[`MCSB_BIT_APP_RESET_OK] = appResetOk_q;
  end

  always @* begin
    voltWord = `MCSB_RESET_VALUE;
    voltWord[31:16] = voltage_q[15:0];
    voltWord[15:1] = speedCmd_q[14:0];
    voltWord[`MCSB_BIT_SERIAL_ENTRY] = serialEntry_q;
  end

  always @* begin
    stateWord = `MCSB_RESET_VALUE;
    stateWord[31:28] = state_q;
    stateWord[`MCSB_BIT_SELFTEST_FAULT] = selftestFault_q;
    stateWord[15:0] = speed_q[15:0];
  end

  always @* begin
    powerWord = {busCurrent_q, power_q};
  end

  // ==========================================================================
  // Register access
  wire [2:0] accessSel;
  wire accessReq;
  reg [31:0] readMux;

  assign accessSel = decodeOffset(regAddr);
  assign accessReq = regRdEn | regWrEn;

  always @* begin
    case (accessSel)
      SEL_FAULT: readMux = faultWord;
      SEL_VOLT: readMux = voltWord;
      SEL_STATE: readMux = stateWord;
      SEL_POWER: readMux = powerWord;
      default: readMux = `MCSB_RESET_VALUE;
    endcase
  end

  // Write data is never stored: every field is read-only, so a write earns only an acknowledge, or an address error at an unmapped offset.
  always @(posedge clk) begin
    if (rst) begin
      regRdData <= `MCSB_RESET_VALUE;
      regAck <= 1'b0;
      regAddrErr <= 1'b0;
      faultSummary <= 1'b0;
    end else if (clkEn) begin
      regAck <= accessReq && (accessSel != SEL_NONE);
      regAddrErr <= accessReq && (accessSel == SEL_NONE);
      if (regRdEn && !regWrEn) begin
        regRdData <= readMux;
      end
      faultSummary <= |faultFlags;
    end
  end

  // Write data is deliberately unused beyond the strobe.
  wire unusedWrData;
  assign unusedWrData = ^regWrData;

endmodule // mcsb_status_bank

// ---- bench/mcsb_status_bank_monitor.sv ----
// Port-level checker for the status bank.
// Assumes the bench keeps clkEn high while it drives traffic.
`timescale 1ns/100ps
`include "mcsb_regs.vh"
module mcsb_status_bank_monitor (
  input wire clk,
  input wire rst,
  input wire clkEn,
  input wire abnormalSpeedLock,
  input wire syncLostLock,
  input wire motorAbsentFault,
  input wire lockCurrentLimitFault,
  input wire clearFaultsCmd,
  input wire [`MCSB_ADDR_W-1:0] regAddr,
  input wire regRdEn,
  input wire regWrEn,
  input wire [31:0] regRdData,
  input wire regAck,
  input wire regAddrErr,
  input wire faultSummary,
  input wire motorLockAny
);
  // ==========================================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire lockEv = abnormalSpeedLock | syncLostLock | motorAbsentFault | lockCurrentLimitFault;
  wire mapped = regAddr == `MCSB_OFS_CTRL_FAULT || regAddr == `MCSB_OFS_STATUS_VOLT ||
    regAddr == `MCSB_OFS_STATUS_STATE || regAddr == `MCSB_OFS_STATUS_POWER;
  sequence s_req;
    clkEn && (regRdEn || regWrEn);
  endsequence
  sequence s_rdFault;
    clkEn && regRdEn && !regWrEn && regAddr == `MCSB_OFS_CTRL_FAULT;
  endsequence
  property p_lockSet;
    clkEn && lockEv |=> motorLockAny;
  endproperty
  a_lockSet: assert property (p_lockSet) else $error("lock flag missed");
  property p_lockClr;
    clkEn && clearFaultsCmd && !lockEv |=> !motorLockAny;
  endproperty
  a_lockClr: assert property (p_lockClr) else $error("lock flag not cleared");
  property p_sumSet;
    clkEn && motorLockAny |=> faultSummary;
  endproperty
  a_sumSet: assert property (p_sumSet) else $error("summary missed");
  property p_rdSum;
    s_rdFault |=> regRdData[31] == (|regRdData[29:15]);
  endproperty
  a_rdSum: assert property (p_rdSum) else $error("summary bit wrong");
  property p_rdLock;
    s_rdFault |=> regRdData[20] ==
      (regRdData[23] | regRdData[22] | regRdData[21] | regRdData[18]);
  endproperty
  a_rdLock: assert property (p_rdLock) else $error("lock bit wrong");
  property p_ack;
    s_req ##0 mapped |=> regAck && !regAddrErr;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_err;
    clkEn && regRdEn && !mapped |=> regAddrErr && !regAck && regRdData == 32'h0000_0000;
  endproperty
  a_err: assert property (p_err) else $error("no address error");
  property p_wrKeep;
    clkEn && regWrEn && !regRdEn |=> $stable(regRdData);
  endproperty
  a_wrKeep: assert property (p_wrKeep) else $error("write changed data");
  property p_idle;
    clkEn && !regRdEn && !regWrEn |=> !regAck && !regAddrErr;
  endproperty
  a_idle: assert property (p_idle) else $error("spurious answer");
endmodule // mcsb_status_bank_monitor
bind mcsb_status_bank mcsb_status_bank_monitor u_mon (.*);

// ---- bench/mcsb_host_model.sv ----
// Host model: one-cycle read strobes, and write strobes to mapped offsets only, to the bank.
// Assumes one transfer at a time, called from the bench.
`timescale 1ns/100ps
module mcsb_host_model (
  input wire clk,
  output logic [7:0] regAddr,
  output logic regRdEn,
  output logic regWrEn,
  output logic [31:0] regWrData,
  input wire [31:0] regRdData,
  input wire regAck,
  input wire regAddrErr
);
  // ==========================================================================
  // Transfer
  initial begin
    regAddr = 8'h00;
    regRdEn = 1'b0;
    regWrEn = 1'b0;
    regWrData = 32'hFFFF_FFFF;
  end
  task automatic xfer(input logic w, input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= !w;
    regWrEn <= w && (a == 8'hE2 || a == 8'hE4 || a == 8'hEA || a == 8'hEC);
    @(posedge clk);
    regRdEn <= 1'b0;
    regWrEn <= 1'b0;
    #1;
    d = regRdData;
    r = {regAddrErr, regAck};
  endtask
endmodule // mcsb_host_model

// ---- bench/mcsb_status_bank_bench.sv ----
// Self-checking bench for the status bank, driven through the host model.
// Assumes the checker binds itself to the bank.
`timescale 1ns/100ps
module mcsb_status_bank_bench;
  // ==========================================================================
  // Stimulus and checks
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [10:0] ev = 11'h000;
  logic clr = 1'b0;
  logic [3:0] st = 4'h0;
  logic ld = 1'b0;
  logic ent = 1'b0;
  logic [3:0] vld = 4'h0;
  logic [3:0] cs = 4'h0;
  logic [15:0] val = 16'h0000;
  wire [7:0] addr;
  wire rdEn;
  wire wrEn;
  wire [31:0] wrData;
  wire [31:0] rdData;
  wire ack;
  wire err;
  wire lockAny;
  wire sum;
  logic en = 1'b1;
  int failures = 0;
  int comparisons = 0;
  logic [31:0] d;
  logic [1:0] r;
  logic [31:0] e;
  logic [3:0] last;
  int pos [11] = '{29, 28, 27, 23, 22, 21, 19, 18, 17, 16, 15};
  logic [10:0] lockM = 11'h0B8;
  logic [7:0] regs [4] = '{8'hE2, 8'hE4, 8'hEA, 8'hEC};
  always #12.5 clk = ~clk;
  mcsb_status_bank DUT (
    .clk(clk), .rst(rst), .clkEn(en),
    .posdetFreqFault(ev[0]), .posdetTiming1Fault(ev[1]), .posdetTiming2Fault(ev[2]),
    .abnormalSpeedLock(ev[3]), .syncLostLock(ev[4]), .motorAbsentFault(ev[5]),
    .cycleCurrentLimitFault(ev[6]), .lockCurrentLimitFault(ev[7]), .motorSupplyLow(ev[8]),
    .motorSupplyHigh(ev[9]), .extWatchdogExpired(ev[10]), .clearFaultsCmd(clr),
    .selftestEnabled(st[3]), .selftestPass(st[2]), .selftestFault(st[1]), .appResetOk(st[0]),
    .statusLoad(ld), .serialEntryDone(ent), .inputVoltageValue(val), .voltageValid(vld[0]),
    .speedCmdValue(val[14:0]), .speedCmdValid(vld[1]), .ctrlState(cs),
    .motorSpeedValue(val), .motorSpeedValid(vld[2]), .busCurrentValue(val),
    .inputPowerValue(~val), .powerValid(vld[3]), .regAddr(addr), .regRdEn(rdEn),
    .regWrEn(wrEn), .regWrData(wrData), .regRdData(rdData), .regAck(ack),
    .regAddrErr(err), .faultSummary(sum), .motorLockAny(lockAny)
  );
  mcsb_host_model host (.clk(clk), .regAddr(addr), .regRdEn(rdEn), .regWrEn(wrEn),
    .regWrData(wrData), .regRdData(rdData), .regAck(ack), .regAddrErr(err));
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic [1:0] xr);
    host.xfer(1'b0, a, d, r);
    chk("data", x, d);
    chk("resp", {30'h0, xr}, {30'h0, r});
  endtask
  task automatic pulse(input logic [10:0] f, input logic c);
    @(posedge clk);
    ev <= f;
    clr <= c;
    @(posedge clk);
    ev <= 11'h000;
    clr <= 1'b0;
  endtask
  task automatic load(input logic [3:0] s);
    @(posedge clk);
    st <= s;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
  endtask
  task automatic rstAll();
    @(posedge clk);
    rst <= 1'b1;
    ent <= 1'b0;
    cs <= 4'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (regs[k]) rdc(regs[k], 32'h0000_0000, 2'b01);
  endtask
  task automatic test_done();
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    rstAll();
    for (int i = 0; i < 11; i++) begin
      e = 32'h8000_0000 | (32'h0000_0001 << pos[i]);
      if (lockM[i]) e = e | 32'h0010_0000;
      pulse(11'h001 << i, 1'b0);
      rdc(8'hE2, e, 2'b01);
      chk("lockAny", {31'h0, lockM[i]}, {31'h0, lockAny});
      chk("summary", 32'h0000_0001, {31'h0, sum});
      pulse(11'h000, 1'b1);
      rdc(8'hE2, 32'h0000_0000, 2'b01);
      chk("summary", 32'h0000_0000, {31'h0, sum});
    end
    pulse(11'h001, 1'b1);
    rdc(8'hE2, 32'hA000_0000, 2'b01);
    pulse(11'h000, 1'b1);
    load(4'hF);
    rdc(8'hE2, 32'h0000_0007, 2'b01);
    @(posedge clk);
    val <= 16'h7FFF;
    vld <= 4'hF;
    ent <= 1'b1;
    @(posedge clk);
    val <= 16'hABCD;
    vld <= 4'h1;
    @(posedge clk);
    vld <= 4'h0;
    rdc(8'hE4, 32'hABCD_FFFF, 2'b01);
    rdc(8'hEC, 32'h7FFF_8000, 2'b01);
    host.xfer(1'b1, 8'hE4, d, r);
    chk("wrResp", 32'h0000_0001, {30'h0, r});
    rdc(8'hE4, 32'hABCD_FFFF, 2'b01);
    rdc(8'hE6, 32'h0000_0000, 2'b10);
    last = 4'h0;
    for (int c = 0; c < 16; c++) begin
      @(posedge clk);
      cs <= c[3:0];
      if (!(c inside {11, 14, 15})) last = c[3:0];
      rdc(8'hEA, {last, 10'h000, 1'b1, 1'b0, 16'h7FFF}, 2'b01);
    end
    load(4'h8);
    pulse(11'h000, 1'b1);
    rdc(8'hE2, 32'h0000_0004, 2'b01);
    // A lock event while the clock enable is low must leave every flag untouched.
    @(posedge clk);
    en <= 1'b0;
    pulse(11'h008, 1'b0);
    en <= 1'b1;
    rdc(8'hE2, 32'h0000_0004, 2'b01);
    chk("lockAny", 32'h0000_0000, {31'h0, lockAny});
    rstAll();
    test_done();
  end
  // The run needs under a thousand cycles; this limit leaves ample margin.
  initial begin
    #200000;
    failures++;
    test_done();
  end
endmodule // mcsb_status_bank_bench
